// [hdl/eiobb_pkg.sv]
package eiobb_pkg;
    localparam int EIOBB_CLK_MHZ = 125;
    // io space word address: bit 22 picks the half
    localparam int EIOBB_HALF_BIT = 22;
    localparam int EIOBB_SPEED_LO = 19;
    localparam int EIOBB_SLOT_LO = 13;
    localparam int EIOBB_DIRECT_USED_HI = 21;
    localparam int EIOBB_DIRECT_USED_LO = 15;
    localparam logic [3:0] EIOBB_SLOT_NONE = 4'h0;
    localparam logic [15:0] EIOBB_DATA_RESET = 16'h0000;
    // controller cycle lengths in ns, per speed code
    localparam int EIOBB_SLOW_NS = 560;
    localparam int EIOBB_MEDIUM_NS = 440;
    localparam int EIOBB_FAST_NS = 320;
    localparam int EIOBB_SYNC_NS = 200;
    localparam int EIOBB_SLOW_CYC = EIOBB_SLOW_NS * EIOBB_CLK_MHZ / 1000;
    localparam int EIOBB_MEDIUM_CYC = EIOBB_MEDIUM_NS * EIOBB_CLK_MHZ / 1000;
    localparam int EIOBB_FAST_CYC = EIOBB_FAST_NS * EIOBB_CLK_MHZ / 1000;
    localparam int EIOBB_SYNC_CYC = EIOBB_SYNC_NS * EIOBB_CLK_MHZ / 1000;
    localparam logic [1:0] EIOBB_SPEED_SLOW = 2'h0;
    localparam logic [1:0] EIOBB_SPEED_MEDIUM = 2'h1;
    localparam logic [1:0] EIOBB_SPEED_FAST = 2'h2;
    localparam logic [1:0] EIOBB_SPEED_SYNC = 2'h3;
    typedef enum {
        EIOBB_IDLE,
        EIOBB_CTL,
        EIOBB_DIRECT,
        EIOBB_DONE
    } eiobb_state_t;
endpackage

// [hdl/eiobb_decode.sv]
`timescale 1ns/10ps
module eiobb_decode
    import eiobb_pkg::*;
(
    input wire logic [22:2] word_addr, // io space word address
    output logic ctl_space, // upper half, controller timed
    output logic direct_space, // decoded direct-attached window
    output logic [1:0] speed, // controller cycle speed
    output logic [3:0] slot_sel // one-hot slot select
);
    wire logic [1:0] slot_num;
    wire logic direct_used;
    wire logic hit;

    assign ctl_space = word_addr[EIOBB_HALF_BIT];
    // only the low part of the lower half is decoded
    assign direct_used = ~word_addr[EIOBB_HALF_BIT]
        & (word_addr[EIOBB_DIRECT_USED_HI:EIOBB_DIRECT_USED_LO] == 7'h00);
    assign direct_space = direct_used;
    assign speed = word_addr[EIOBB_SPEED_LO+1:EIOBB_SPEED_LO];
    // slot number sits just above the 8 kbyte offset
    assign slot_num = word_addr[EIOBB_SLOT_LO+1:EIOBB_SLOT_LO];
    assign hit = ctl_space | direct_used;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_slot
            assign slot_sel[i] = hit & (slot_num == 2'(i));
        end
    endgenerate
endmodule

// [hdl/eiobb_bridge.sv]
// Function
// - 16-bit io data, word address 2..21
// - bridge latches isolate and time io bus
// - address picks one of four speeds
// - upper half controller, lower half direct
// - only low part of direct half decoded
// - four equal slot windows, slots 0-3
// - direct windows are 8 kbytes each
// - direct cards use request/grant handshake
// - writes drive io lanes from bits 16-31
// - reads return io lanes on bits 0-15
// - byte cards answer on lowest byte
// - read upper half-word is undefined
`timescale 1ns/10ps
module eiobb_bridge
    import eiobb_pkg::*;
(
    input wire logic clk, // 125 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic cpu_req, // access request, level
    input wire logic cpu_write, // 1 write, 0 read
    input wire logic [22:2] cpu_addr, // io space word address
    input wire logic [31:0] cpu_wdata, // main bus write data
    output logic [31:0] cpu_rdata, // main bus read data
    output logic cpu_ack, // access done, one cycle
    output logic cpu_unmapped, // access hit unused space
    output logic [21:2] buffered_io_word_address, // io address
    input wire logic [15:0] io_data_lanes_in, // io data from bus
    output logic [15:0] io_data_lanes_out, // io data to bus
    output logic io_data_lanes_oe, // high while driving lanes
    output logic io_read_n, // controller read strobe
    output logic io_write_n, // controller write strobe
    output logic [3:0] slot_select, // per-slot select
    output logic direct_req_n, // request to direct cards
    input wire logic direct_grant_n // grant from direct card
);
    ////////////////////////////////////////////////////////////////
    eiobb_state_t state;
    eiobb_state_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [15:0] wlatch;
    logic [15:0] rlatch;
    logic writing;
    logic [1:0] grant_sync;
    logic [15:0] data_meta;
    logic [15:0] data_sync;

    wire logic dec_ctl;
    wire logic dec_direct;
    wire logic [1:0] dec_speed;
    wire logic [3:0] dec_slot;
    wire logic [7:0] speed_len;
    wire logic grant;
    wire logic start;
    wire logic grant_busy;
    wire logic ctl_end;
    wire logic dir_end;

    eiobb_decode u_decode (
        .word_addr(cpu_addr),
        .ctl_space(dec_ctl),
        .direct_space(dec_direct),
        .speed(dec_speed),
        .slot_sel(dec_slot)
    );

    ////////////////////////////////////////////////////////////////
    // pins pass two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            grant_sync <= 2'h0;
        end else begin
            grant_sync <= {grant_sync[0], ~direct_grant_n};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_meta <= EIOBB_DATA_RESET;
            data_sync <= EIOBB_DATA_RESET;
        end else begin
            data_meta <= io_data_lanes_in;
            data_sync <= data_meta;
        end
    end
    assign grant = grant_sync[1];

    ////////////////////////////////////////////////////////////////
    // cycle length chosen by address speed field
    assign speed_len =
        (dec_speed == EIOBB_SPEED_SLOW) ? 8'(EIOBB_SLOW_CYC) :
        (dec_speed == EIOBB_SPEED_MEDIUM) ? 8'(EIOBB_MEDIUM_CYC) :
        (dec_speed == EIOBB_SPEED_FAST) ? 8'(EIOBB_FAST_CYC) :
        8'(EIOBB_SYNC_CYC);
    // a grant left over from the last direct cycle must drain first
    assign grant_busy = dec_direct & grant;
    assign start = (state == EIOBB_IDLE) & cpu_req & ~grant_busy;
    assign ctl_end = (state == EIOBB_CTL) & (count == 8'h01);
    assign dir_end = (state == EIOBB_DIRECT) & grant;

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            EIOBB_IDLE: begin
                if (start & dec_ctl) begin
                    next_state = EIOBB_CTL;
                    next_count = speed_len;
                end else if (start & dec_direct) begin
                    next_state = EIOBB_DIRECT;
                end else if (start) begin
                    next_state = EIOBB_DONE;
                end
            end
            EIOBB_CTL: begin
                next_count = count - 8'h01;
                if (count == 8'h01) begin
                    next_state = EIOBB_DONE;
                end
            end
            EIOBB_DIRECT: begin
                if (grant) begin
                    next_state = EIOBB_DONE;
                end
            end
            EIOBB_DONE: begin
                if (!cpu_req) begin
                    next_state = EIOBB_IDLE;
                end
            end
            default: begin
                next_state = EIOBB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= EIOBB_IDLE;
            count <= 8'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////
    // latches and address hold for the whole io cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            wlatch <= EIOBB_DATA_RESET;
        end else if (start) begin
            wlatch <= cpu_wdata[31:16];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            writing <= 1'b0;
        end else if (start) begin
            writing <= cpu_write;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            buffered_io_word_address <= 20'h00000;
        end else if (start) begin
            buffered_io_word_address <= cpu_addr[21:2];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_unmapped <= 1'b0;
        end else if (start) begin
            cpu_unmapped <= ~(dec_ctl | dec_direct);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            slot_select <= EIOBB_SLOT_NONE;
        end else if (start) begin
            slot_select <= dec_slot;
        end else if (state == EIOBB_DONE) begin
            slot_select <= EIOBB_SLOT_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rlatch <= EIOBB_DATA_RESET;
        end else if ((ctl_end | dir_end) & ~writing) begin
            rlatch <= data_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_ack <= 1'b0;
        end else begin
            cpu_ack <= (next_state == EIOBB_DONE)
                & (state != EIOBB_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////
    wire logic busy;
    assign busy = (state == EIOBB_CTL) | (state == EIOBB_DIRECT);
    assign io_data_lanes_out = wlatch;
    assign io_data_lanes_oe = busy & writing;
    assign io_write_n = ~((state == EIOBB_CTL) & writing);
    assign io_read_n = ~((state == EIOBB_CTL) & ~writing);
    assign direct_req_n = ~(state == EIOBB_DIRECT);
    // upper half-word has no defined value; held at zero
    assign cpu_rdata = {16'h0000, rlatch};
endmodule

// [test/eiobb_bridge_assertions.sv]
`timescale 1ns/10ps
module eiobb_bridge_assertions
    import eiobb_pkg::*;
(
    input logic clk, // clock
    input logic reset, // reset
    input logic cpu_write, // direction
    input logic [22:2] cpu_addr, // address
    input logic [31:0] cpu_wdata, // wdata
    input logic [31:0] cpu_rdata, // rdata
    input logic cpu_ack, // done
    input logic [21:2] buffered_io_word_address, // io addr
    input logic [15:0] io_data_lanes_out, // lanes
    input logic io_data_lanes_oe, // lane enable
    input logic io_read_n, // read strobe
    input logic io_write_n, // write strobe
    input logic [3:0] slot_select, // slots
    input logic direct_req_n // direct req
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
sequence ctl_on;
    !io_read_n || !io_write_n;
endsequence
sequence any_on;
    !io_read_n || !io_write_n || !direct_req_n;
endsequence
a_slot_onehot: assert property (any_on |-> $onehot(slot_select))
    else $error("slot select not one-hot");
a_slot_place: assert property (
    any_on |-> slot_select == 4'h1 << cpu_addr[14:13])
    else $error("wrong slot");
a_ctl_half: assert property (ctl_on |-> cpu_addr[22])
    else $error("strobe in lower half");
a_direct_low: assert property (
    !direct_req_n |-> !cpu_addr[22] && cpu_addr[21:15] == 7'h00)
    else $error("direct request off window");
a_addr_out: assert property (
    any_on |-> buffered_io_word_address == cpu_addr[21:2])
    else $error("io address wrong");
a_write_lanes: assert property (
    !io_write_n |-> io_data_lanes_oe && io_data_lanes_out == cpu_wdata[31:16])
    else $error("write lanes wrong");
a_read_float: assert property (!io_read_n |-> !io_data_lanes_oe)
    else $error("lanes driven on read");
a_read_upper: assert property (
    cpu_ack && !cpu_write |-> cpu_rdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
    else $error("ack longer than one cycle");
endmodule
bind eiobb_bridge eiobb_bridge_assertions u_chk (.clk, .reset, .cpu_write,
    .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .buffered_io_word_address,
    .io_data_lanes_out, .io_data_lanes_oe, .io_read_n, .io_write_n,
    .slot_select, .direct_req_n);

// [test/eiobb_card_model.sv]
`timescale 1ns/10ps
module eiobb_card_model (
    input logic clk, // clock
    input logic [21:2] io_addr, // io word address
    input logic io_read_n, // read strobe
    input logic direct_req_n, // direct req
    input logic [3:0] slot_select, // slots
    output logic [15:0] io_data_lanes_in, // data out
    output logic direct_grant_n // grant
);
logic [2:0] wait_cnt = 3'h0;
logic [15:0] last = 16'h0000;
// identity area size and contents are the card's choice; values arbitrary
localparam logic [10:0] ID_WORDS = 11'h004;
localparam logic [7:0] ID_BYTE = 8'hc3;
logic drive;
logic id_area;
assign drive = !io_read_n || !direct_req_n;
assign id_area = io_addr[12:2] < ID_WORDS;
// byte card answers on the low byte; released lanes show inverse
assign io_data_lanes_in = !drive ? ~last
    : id_area ? {8'h00, ID_BYTE}
    : {8'h00, 8'h5a ^ {4'h0, slot_select}};
initial direct_grant_n = 1'b1;
always @(posedge clk) begin
    last <= io_data_lanes_in;
    if (direct_req_n) begin
        wait_cnt <= 3'h0;
        direct_grant_n <= 1'b1;
    end else if (wait_cnt == 3'h3) begin
        direct_grant_n <= 1'b0;
    end else begin
        wait_cnt <= wait_cnt + 3'h1;
    end
end
endmodule

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
import eiobb_pkg::*;
logic clk = 0, reset = 1, cpu_req = 0, cpu_write = 0, ack, unm, oe;
logic [22:2] cpu_addr = 21'h0;
logic [31:0] cpu_wdata = 32'h0, rdata, rd;
logic [21:2] ioa, al;
logic [15:0] lin, lout, wl;
logic rn, wn, rq_n, gn, ol;
logic [3:0] sel, sl;
int n_errors = 0, total_checks = 0, lo;
int cyc[4] = '{EIOBB_SLOW_CYC, EIOBB_MEDIUM_CYC, EIOBB_FAST_CYC,
    EIOBB_SYNC_CYC};
always #4 clk = ~clk;
eiobb_bridge dut (.clk(clk), .reset(reset), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(rdata), .cpu_ack(ack), .cpu_unmapped(unm),
    .buffered_io_word_address(ioa), .io_data_lanes_in(lin),
    .io_data_lanes_out(lout), .io_data_lanes_oe(oe), .io_read_n(rn),
    .io_write_n(wn), .slot_select(sel), .direct_req_n(rq_n),
    .direct_grant_n(gn));
eiobb_card_model card (.clk(clk), .io_addr(ioa), .io_read_n(rn),
    .direct_req_n(rq_n),
    .slot_select(sel), .io_data_lanes_in(lin), .direct_grant_n(gn));
task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (e !== g) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic acc(logic wr, logic [22:2] a, logic [31:0] wd);
    int k;
    k = 0;
    lo = 0;
    sl = 4'h0;
    wl = 16'h0000;
    al = 20'h00000;
    ol = 1'b0;
    cpu_req = 1'b1;
    cpu_write = wr;
    cpu_addr = a;
    cpu_wdata = wd;
    do begin
        @(posedge clk);
        #1;
        k++;
        if (!wn || !rn) lo++;
        if (sel !== 4'h0) sl = sel;
        if (!wn || !rn || !rq_n) begin
            al = ioa;
            ol = oe;
            wl = lout;
        end
    end while (ack !== 1'b1 && k < 300);
    chk("ack", 1, k < 300);
    rd = rdata;
    cpu_req = 1'b0;
    @(posedge clk);
    #1;
endtask
task automatic t_ctl_writes;
    logic [15:0] hw;
    for (int s = 0; s < 4; s++) begin
        hw = {14'h30d5, 2'(s)};
        acc(1, {2'h2, 2'(s), 4'h0, 2'(s), 11'h004}, {hw, hw});
        chk("strobe cycles", cyc[s], lo);
        chk("slot", 4'h1 << s, sl);
        chk("write lanes", hw, wl);
        chk("io address", {1'b0, 2'(s), 4'h0, 2'(s), 11'h004}, al);
        chk("lane enable", 1, ol);
    end
endtask
task automatic t_ctl_read;
    acc(0, {2'h2, 2'h3, 4'h0, 2'h1, 11'h008}, 32'h0);
    chk("read lanes", 16'h0058, rd[15:0]);
    chk("sync cycles", cyc[3], lo);
    chk("read enable", 0, ol);
    acc(0, {2'h2, 2'h0, 4'h0, 2'h0, 11'h001}, 32'h0);
    chk("identity", 16'h00c3, rd[15:0]);
    chk("slow cycles", cyc[0], lo);
endtask
task automatic t_unmapped;
    acc(0, {1'b0, 7'h01, 2'h0, 11'h000}, 32'h0);
    chk("unmapped", 1, unm);
    chk("no slot", 4'h0, sl);
endtask
task automatic t_direct;
    acc(0, {1'b0, 7'h00, 2'h2, 11'h010}, 32'h0);
    chk("direct data", 16'h005e, rd[15:0]);
    chk("direct slot", 4'h4, sl);
    chk("no strobe", 0, lo);
    chk("mapped", 0, unm);
    acc(0, {1'b0, 7'h00, 2'h3, 11'h010}, 32'h0);
    chk("back to back data", 16'h0052, rd[15:0]);
    acc(1, {1'b0, 7'h00, 2'h1, 11'h020}, {4{8'h9c}});
    chk("byte lanes", 16'h9c9c, wl);
    chk("direct enable", 1, ol);
    chk("direct address", {7'h00, 2'h1, 11'h020}, al);
endtask
task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
initial begin
    #60000;
    n_errors++;
    report_and_stop();
end
initial begin
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    t_ctl_writes();
    t_ctl_read();
    t_unmapped();
    t_direct();
    report_and_stop();
end
endmodule
